/* File: rtl/iopu_top.sv */
// General-purpose I/O ports with pull-up control behind an AHB-Lite slave.
//
// Summary of operation
// - Each pin except the two open-drain pins has its own software pull-up enable bit.
// - A pull-up acts only while the pin's direction bit selects input.
// - Port 3 bits 2 and 3 are open-drain and have no pull-up enable bits.
// - An open-drain output holding one turns its driver off and floats.
// - Reading an input bit returns the synchronised, filtered pin level.
// - Reading an output bit returns the latch value.
// - A data write updates all eight latch bits, inputs included.
// - Turning an output into an input keeps its latch contents.
// - After reset every pin is an input.
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`include "iopu_params.svh"
`timescale 1ns/100ps
`default_nettype none

module iopu_top #(
  parameter int NUM_PORTS = `IOPU_NUM_PORTS,
  parameter int PORT_W = `IOPU_PORT_W
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire iopu_pkg::iopu_ahb_req_type ahb_req_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_i,
  output logic [NUM_PORTS*PORT_W-1:0] pin_o,
  output logic [NUM_PORTS*PORT_W-1:0] pin_oe_o,
  output logic [NUM_PORTS*PORT_W-1:0] pullup_en_o
);

  // ****************************************************************
  // Address phase decode
  // ****************************************************************
  localparam int PSEL_W = `IOPU_PORT_MSB - `IOPU_PORT_LSB + 1;

  logic take_addr;
  logic addr_mapped;
  logic [PSEL_W-1:0] addr_port;
  logic [1:0] addr_kind;
  logic wr_pend_q;
  logic [PSEL_W-1:0] wr_port_q;
  logic [1:0] wr_kind_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic wr_fire;

  assign take_addr = ahb_req_i.hsel && hready_i &&
    (ahb_req_i.htrans == `IOPU_HTRANS_NONSEQ);
  assign addr_port = ahb_req_i.haddr[`IOPU_PORT_MSB:`IOPU_PORT_LSB];
  assign addr_kind = ahb_req_i.haddr[`IOPU_KIND_MSB:`IOPU_KIND_LSB];
  // Only aligned words of existing ports and the three kinds are mapped.
  assign addr_mapped =
    (ahb_req_i.haddr[31:`IOPU_HIGH_LSB] == '0) &&
    (ahb_req_i.haddr[`IOPU_KIND_LSB-1:0] == '0) &&
    (32'(addr_port) < 32'(NUM_PORTS)) &&
    (addr_kind != `IOPU_KIND_NONE);

  // Write address is held for the data phase that follows.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_q <= 1'b0;
      wr_port_q <= '0;
      wr_kind_q <= 2'h0;
    end else if (hready_i) begin
      wr_pend_q <= take_addr && ahb_req_i.hwrite && addr_mapped;
      wr_port_q <= addr_port;
      wr_kind_q <= addr_kind;
    end
  end

  // A write lands only at the edge that completes its data phase.
  assign wr_fire = wr_pend_q && hready_i;

  // ****************************************************************
  // Per-port registers, pin synchronisers and pin drivers
  // ****************************************************************
  logic [PORT_W-1:0] latch_d [NUM_PORTS];
  logic [PORT_W-1:0] dir_d [NUM_PORTS];
  logic [PORT_W-1:0] pull_d [NUM_PORTS];
  logic [PORT_W-1:0] level_q [NUM_PORTS];

  // One slice of registers and pin logic per port.
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      // Port 3 carries the two open-drain pins.
      localparam logic [PORT_W-1:0] OD_MASK =
        (gp == `IOPU_OD_PORT) ? PORT_W'(`IOPU_OD_MASK) : '0;
      logic sel;
      logic [PORT_W-1:0] latch_q;
      logic [PORT_W-1:0] dir_q;
      logic [PORT_W-1:0] pull_q;
      logic [PORT_W-1:0] sync1_q;
      logic [PORT_W-1:0] sync2_q;
      logic [PORT_W-1:0] sync3_q;
      logic [PORT_W-1:0] lvl_q;
      logic [PORT_W-1:0] out_q;
      logic [PORT_W-1:0] oe_q;
      logic [PORT_W-1:0] pu_q;

      assign sel = wr_fire && (32'(wr_port_q) == gp);

      // All eight latch bits take the written byte.
      // The latch is untouched by direction writes.
      assign latch_d[gp] = (sel && wr_kind_q == `IOPU_KIND_DATA) ?
        hwdata_i[PORT_W-1:0] : latch_q;
      assign dir_d[gp] = (sel && wr_kind_q == `IOPU_KIND_DIR) ?
        hwdata_i[PORT_W-1:0] : dir_q;
      // Open-drain bits have no pull-up bit and read zero.
      assign pull_d[gp] = (sel && wr_kind_q == `IOPU_KIND_PULL) ?
        (hwdata_i[PORT_W-1:0] & ~OD_MASK) : pull_q;
      // Software sees the filtered pin level, never the raw pin.
      assign level_q[gp] = lvl_q;

      // Every pin starts as an input.
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          latch_q <= `IOPU_RST_BYTE;
          dir_q <= `IOPU_RST_BYTE;
          pull_q <= `IOPU_RST_BYTE;
        end else begin
          latch_q <= latch_d[gp];
          dir_q <= dir_d[gp];
          pull_q <= pull_d[gp];
        end
      end

      // ****************************************************************
      // Pin sampling
      // ****************************************************************
      // Three-stage sampler; a level counts once stages two and three agree.
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync1_q <= '0;
          sync2_q <= '0;
          sync3_q <= '0;
          lvl_q <= '0;
        end else begin
          sync1_q <= pin_i[gp*PORT_W +: PORT_W];
          sync2_q <= sync1_q;
          sync3_q <= sync2_q;
          lvl_q <= (sync2_q & sync3_q) | (lvl_q & (sync2_q | sync3_q));
        end
      end

      // ****************************************************************
      // Pin drivers
      // ****************************************************************
      // Pin drivers follow the next register values, so pins change at the same edge as the registers.
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          out_q <= '0;
          oe_q <= '0;
          pu_q <= '0;
        end else begin
          out_q <= latch_d[gp] & ~OD_MASK;
          oe_q <= dir_d[gp] & ~(OD_MASK & latch_d[gp]);
          pu_q <= pull_d[gp] & ~dir_d[gp] & ~OD_MASK;
        end
      end

      assign pin_o[gp*PORT_W +: PORT_W] = out_q;
      assign pin_oe_o[gp*PORT_W +: PORT_W] = oe_q;
      assign pullup_en_o[gp*PORT_W +: PORT_W] = pu_q;
    end
  endgenerate

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rd_value;

  // Next values are read, so a read after a write sees the new byte.
  // Inputs read the pin, outputs read the latch.
  always_comb begin
    rd_value = '0;
    if (addr_mapped) begin
      unique case (addr_kind)
        `IOPU_KIND_DATA: rd_value[PORT_W-1:0] =
          (dir_d[addr_port] & latch_d[addr_port]) |
          (~dir_d[addr_port] & level_q[addr_port]);
        `IOPU_KIND_DIR: rd_value[PORT_W-1:0] = dir_d[addr_port];
        `IOPU_KIND_PULL: rd_value[PORT_W-1:0] = pull_d[addr_port];
        default: rd_value = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_q <= '0;
    end else if (take_addr && !ahb_req_i.hwrite) begin
      hrdata_q <= rd_value;
    end
  end

  // ****************************************************************
  // Bus response
  // ****************************************************************
  // Every transfer completes at once with an OKAY response.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hreadyout_q <= 1'b0;
      hresp_q <= `IOPU_HRESP_OKAY;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= `IOPU_HRESP_OKAY;
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hreadyout_q;
  assign hresp_o = hresp_q;

endmodule // iopu_top

`default_nettype wire

/* File: shared/iopu_params.svh */
// Constants of the general-purpose port block: sizes, offsets, resets.
`ifndef IOPU_PARAMS_SVH
`define IOPU_PARAMS_SVH

// ****************************************************************
// Port geometry
// ****************************************************************
`define IOPU_NUM_PORTS 7
`define IOPU_PORT_W 8
`define IOPU_OD_PORT 3
`define IOPU_OD_MASK 8'h0c

// ****************************************************************
// Register map: byte address = port * 0x10 + kind * 4
// ****************************************************************
`define IOPU_PORT_LSB 4
`define IOPU_PORT_MSB 6
`define IOPU_KIND_LSB 2
`define IOPU_KIND_MSB 3
`define IOPU_HIGH_LSB 7
`define IOPU_KIND_DATA 2'h0
`define IOPU_KIND_DIR 2'h1
`define IOPU_KIND_PULL 2'h2
`define IOPU_KIND_NONE 2'h3
`define IOPU_OFF_DATA 32'h0000_0000
`define IOPU_OFF_DIR 32'h0000_0004
`define IOPU_OFF_PULL 32'h0000_0008
`define IOPU_PORT_STRIDE 32'h0000_0010

// ****************************************************************
// Reset values and bus codes
// ****************************************************************
`define IOPU_RST_BYTE 8'h00
`define IOPU_HTRANS_NONSEQ 2'h2
`define IOPU_HRESP_OKAY 1'h0

`endif

/* File: shared/iopu_pkg.sv */
// Types shared by the general-purpose port block.
`default_nettype none

package iopu_pkg;

  // AHB-Lite address-phase signals.
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
  } iopu_ahb_req_type;

  // Register kind selected by an address.
  typedef enum logic [1:0] {
    IOPU_REG_DATA = 2'h0,
    IOPU_REG_DIR = 2'h1,
    IOPU_REG_PULL = 2'h2
  } iopu_kind_type;

endpackage

`default_nettype wire

/* File: bench/iopu_sva.sv */
// Checker of the port block's pin outputs after bus writes.
`timescale 1ns/100ps
`default_nettype none
module iopu_sva #(
  parameter int NUM_PORTS = 7,
  parameter int PORT_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire iopu_pkg::iopu_ahb_req_type ahb_req_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_i,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_o,
  input wire logic [NUM_PORTS*PORT_W-1:0] pin_oe_o,
  input wire logic [NUM_PORTS*PORT_W-1:0] pullup_en_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  logic wr_q;
  logic [31:0] a_q;
  logic [2:0] p;
  logic [7:0] m;
  logic ok;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= 1'b0;
      a_q <= '0;
    end else begin
      wr_q <= ahb_req_i.hsel & ahb_req_i.hwrite & hready_i
        & (ahb_req_i.htrans == 2'h2);
      a_q <= ahb_req_i.haddr;
    end
  end
  assign p = a_q[6:4];
  assign m = (p == 3'h3) ? 8'hf3 : 8'hff;
  assign ok = (a_q[31:7] == '0) & (a_q[1:0] == 2'h0) & (p != 3'h7);
  sequence s_wr(logic [1:0] kk);
    wr_q && ok && (a_q[3:2] == kk);
  endsequence
  property p_dir;
    s_wr(2'h1) |=> ((pin_oe_o[$past(p)*8 +: 8] ^ $past(hwdata_i[7:0]))
      & $past(m)) == 8'h00;
  endproperty
  a_dir: assert property (p_dir) else $error("oe differs from dir");
  property p_lat;
    s_wr(2'h0) |=> ((pin_o[$past(p)*8 +: 8] ^ $past(hwdata_i[7:0]))
      & pin_oe_o[$past(p)*8 +: 8] & $past(m)) == 8'h00;
  endproperty
  a_lat: assert property (p_lat) else $error("pin differs from latch");
  property p_pull;
    s_wr(2'h2) |=> (pullup_en_o[$past(p)*8 +: 8] ^ ($past(hwdata_i[7:0])
      & ~pin_oe_o[$past(p)*8 +: 8] & $past(m))) == 8'h00;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
  property p_hold;
    !wr_q |=> $stable(pin_oe_o) && $stable(pin_o) && $stable(pullup_en_o);
  endproperty
  a_hold: assert property (p_hold) else $error("pins moved alone");
  property p_rst;
    !$past(rst_b_i) |-> (pin_oe_o == '0) && (pullup_en_o == '0);
  endproperty
  a_rst: assert property (p_rst) else $error("pin not input");
  property p_pu_in;
    (pullup_en_o & pin_oe_o) == '0;
  endproperty
  a_pu_in: assert property (p_pu_in) else $error("pull on output");
  property p_od_pu;
    pullup_en_o[27:26] == 2'b00;
  endproperty
  a_od_pu: assert property (p_od_pu) else $error("open-drain pull");
  property p_od_hi;
    pin_o[27:26] == 2'b00;
  endproperty
  a_od_hi: assert property (p_od_hi) else $error("open-drain high");
  property p_od_off;
    s_wr(2'h0) ##0 (p == 3'h3) |=>
      (pin_oe_o[27:26] & $past(hwdata_i[3:2])) == 2'b00;
  endproperty
  a_od_off: assert property (p_od_off) else $error("od not off");
endmodule // iopu_sva
bind iopu_top iopu_sva #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) u_sva (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .ahb_req_i(ahb_req_i),
  .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o));
`default_nettype wire

/* File: bench/iopu_pins_model.sv */
// Outside circuitry that settles the level of every pin.
`timescale 1ns/100ps
`default_nettype none
module iopu_pins_model (
  input wire logic clock_i,
  input wire logic [55:0] pin_o_i,
  input wire logic [55:0] oe_i,
  input wire logic [55:0] pu_i,
  input wire logic [55:0] ext_i,
  input wire logic [55:0] ext_en_i,
  output logic [55:0] pin_i_o
);
  logic [55:0] t_q = '0;
  // A floating pin wanders every cycle.
  always @(posedge clock_i) begin
    t_q <= ~t_q;
  end
  // Driver wins, then outside drive, then pull-up, else floating.
  assign pin_i_o = (oe_i & pin_o_i)
    | (~oe_i & ((ext_en_i & ext_i) | (~ext_en_i & (pu_i | t_q))));
endmodule // iopu_pins_model
`default_nettype wire

/* File: bench/io_port_pullup_latch_tb_top.sv */
// Self-checking bench of the port block.
`timescale 1ns/100ps
`default_nettype none
module io_port_pullup_latch_tb_top;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  iopu_pkg::iopu_ahb_req_type req = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic rdy;
  logic resp;
  logic rd_ph = 1'b0;
  logic [55:0] pin_in, pin_out, oe, pu;
  logic [55:0] ext = '0;
  logic [55:0] ext_en = '1;
  logic [7:0] dir_s[7] = '{default: 8'h00};
  logic [7:0] lat_s[7] = '{default: 8'h00};
  logic [7:0] pul_s[7] = '{default: 8'h00};
  logic [7:0] q[$];
  logic [31:0] seed = 32'd10093;
  int errors = 0;
  int total_checks = 0;
  iopu_top DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .ahb_req_i(req),
    .hready_i(rdy), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(rdy), .hresp_o(resp), .pin_i(pin_in), .pin_o(pin_out),
    .pin_oe_o(oe), .pullup_en_o(pu));
  iopu_pins_model u_pins (.clock_i(clock_i), .pin_o_i(pin_out), .oe_i(oe),
    .pu_i(pu), .ext_i(ext), .ext_en_i(ext_en), .pin_i_o(pin_in));
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [7:0] d, input logic [7:0] e);
    req <= '{1'b1, a, 2'h2, w, 3'h2};
    @(posedge clock_i);
    while (!rdy) @(posedge clock_i);
    req.htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rd_ph <= !w;
    if (!w) q.push_back(e);
    @(posedge clock_i);
    while (!rdy) @(posedge clock_i);
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input int p, input int k, input logic [7:0] d);
    xfer(p * 16 + k * 4, 1'b1, d, 8'h00);
    if (k == 0) lat_s[p] = d;
    if (k == 1) dir_s[p] = d;
    if (k == 2) pul_s[p] = d & ((p == 3) ? 8'hf3 : 8'hff);
  endtask
  task automatic rd(input int p, input int k);
    logic [7:0] v;
    logic [7:0] e;
    v = (ext_en[p*8 +: 8] & ext[p*8 +: 8]) | (~ext_en[p*8 +: 8] & pul_s[p]);
    e = (dir_s[p] & lat_s[p]) | (~dir_s[p] & v);
    xfer(p * 16 + k * 4, 1'b0, 8'h00, (k == 1) ? dir_s[p] : (k == 2) ?
      pul_s[p] : e);
  endtask
  task automatic rd_all(input int kn);
    repeat (8) @(posedge clock_i);
    for (int p = 0; p < 7; p++) for (int k = 0; k < kn; k++) rd(p, k);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    if (rst_b_i && rdy && (resp !== 1'b0)) begin
      errors++;
      $display("mismatch at %0t: response not okay", $time);
    end
    if (rd_ph && rdy) begin
      total_checks++;
      if (hrdata !== {24'h0, q[0]}) begin
        errors++;
        $display("mismatch at %0t: read %h not %h", $time, hrdata, q[0]);
      end
      void'(q.pop_front());
    end
  end
  initial begin
    for (int i = 0; i < 7; i++) ext[i*8 +: 8] = rnd();
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rd_all(3);
    for (int p = 0; p < 7; p++) for (int k = 0; k < 3; k++) wr(p, k, rnd());
    rd_all(3);
    for (int p = 0; p < 7; p++) wr(p, 0, rnd());
    for (int p = 0; p < 7; p++) wr(p, 1, 8'hff);
    rd_all(1);
    for (int p = 0; p < 7; p++) wr(p, 1, 8'h00);
    rd_all(1);
    for (int p = 0; p < 7; p++) wr(p, 1, 8'hff);
    rd_all(1);
    ext_en <= 56'h00_0000_0c00_0000;
    for (int p = 0; p < 7; p++) wr(p, 2, 8'hff);
    for (int p = 0; p < 7; p++) wr(p, 1, 8'h0f);
    rd_all(3);
    ext_en <= '1;
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    dir_s = '{default: 8'h00};
    lat_s = '{default: 8'h00};
    pul_s = '{default: 8'h00};
    rd_all(3);
    xfer(32'h70, 1'b1, 8'hff, 8'h00);
    xfer(32'h70, 1'b0, 8'h00, 8'h00);
    xfer(32'h0c, 1'b0, 8'h00, 8'h00);
    xfer(32'h01, 1'b0, 8'h00, 8'h00);
    results();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    $display("mismatch at %0t: timeout", $time);
    results();
  end
endmodule // io_port_pullup_latch_tb_top
`default_nettype wire
